/* File: verilog/wdit_defs.vh */
`ifndef WDIT_DEFS_VH
`define WDIT_DEFS_VH
// control word field positions
`define WDIT_KEY_WRITE      8'h5a
`define WDIT_KEY_READ       8'h69
`define WDIT_BIT_HALT       7
`define WDIT_BIT_NMIES      6
`define WDIT_BIT_NMI        5
`define WDIT_BIT_MODE       4
`define WDIT_BIT_CLEAR      3
`define WDIT_BIT_CLKSEL     2
`define WDIT_IVL_HI         1
`define WDIT_IVL_LO         0
`define WDIT_CTL_RESET      8'h00
// counter bit that marks expiry for each interval code
`define WDIT_TAP_32768      4'd15
`define WDIT_TAP_8192       4'd13
`define WDIT_TAP_512        4'd9
`define WDIT_TAP_64         4'd6
// restart pulse count at which the pulse ends; the pulse lasts 5 reference clocks
`define WDIT_RESET_PULSE    4'd4
`endif

/* File: verilog/wdit_count.v */
`timescale 1ns/10ps
`include "wdit_defs.vh"
module wdit_count #(
    parameter WIDTH = 16
) (
    input  wire             i_ref_clk,
    input  wire             i_rst_n,
    input  wire             i_clear,
    input  wire             i_tick,
    output reg  [WIDTH-1:0] o_count
);
    // free up-counter with no software path; clear wins over tick
    always @(posedge i_ref_clk) begin
        if (!i_rst_n || i_clear) begin
            o_count <= {WIDTH{1'b0}};
        end else if (i_tick) begin
            o_count <= o_count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule // wdit_count

/* File: verilog/wdit_timer.v */
`timescale 1ns/10ps
`include "wdit_defs.vh"
module wdit_timer #(
    parameter WIDTH = 16
) (
    input  wire        i_ref_clk,
    input  wire        i_rst_n,
    input  wire        i_aux_tick,
    input  wire        i_sub_main_tick,
    input  wire        i_raw_osc_tick,
    input  wire        i_main_tick,
    input  wire        i_aux_fail,
    input  wire        i_sub_main_fail,
    input  wire        i_wr,
    input  wire [15:0] i_wdata,
    input  wire        i_flag_clear,
    output reg  [15:0] o_wd_control_word,
    output reg         o_power_up_clear_reset,
    output reg         o_wd_interval_flag,
    output reg         o_key_violation,
    output reg         o_pin_nmi,
    output reg         o_pin_nmi_falling
);
    localparam ST_RUN   = 1'b0;
    localparam ST_RESET = 1'b1;

    reg             state;
    reg [3:0]       pulse_cnt;
    reg [7:0]       ctl;
    reg             boot_raw;   // still on the raw oscillator after restart
    reg             prev_tap;
    reg             clr_pulse;
    wire [WIDTH-1:0] wd_count;
    reg             tick;
    reg             tap;
    reg             key_bad;
    reg             expire;
    reg             next_state;

    // which counter bit marks the chosen interval
    function [3:0] tap_sel;
        input [1:0] code;
        begin
            case (code)
                2'b00:   tap_sel = `WDIT_TAP_32768;
                2'b01:   tap_sel = `WDIT_TAP_8192;
                2'b10:   tap_sel = `WDIT_TAP_512;
                default: tap_sel = `WDIT_TAP_64;
            endcase
        end
    endfunction

    wire wr_ok = i_wr && (i_wdata[15:8] == `WDIT_KEY_WRITE);

    // clock source choice with fail-safe fallback to main clock in watchdog mode only
    always @* begin
        if (boot_raw) begin
            tick = i_raw_osc_tick;
        end else if (ctl[`WDIT_BIT_CLKSEL]) begin
            tick = (!ctl[`WDIT_BIT_MODE] && i_aux_fail) ? i_main_tick : i_aux_tick;
        end else begin
            tick = (!ctl[`WDIT_BIT_MODE] && i_sub_main_fail) ? i_main_tick : i_sub_main_tick;
        end
        tick = tick && !ctl[`WDIT_BIT_HALT] && (state == ST_RUN);
        tap = wd_count[tap_sel(ctl[`WDIT_IVL_HI:`WDIT_IVL_LO])];
        key_bad = i_wr && !wr_ok && (state == ST_RUN);
        // a halted counter must not expire even if an interval change exposes a set tap bit
        expire = tap && !prev_tap && !clr_pulse && !ctl[`WDIT_BIT_HALT];
        next_state = state;
        if (state == ST_RUN && (key_bad || (expire && !ctl[`WDIT_BIT_MODE]))) begin
            next_state = ST_RESET;
        end else if (state == ST_RESET && pulse_cnt == `WDIT_RESET_PULSE) begin
            next_state = ST_RUN;
        end
    end

    // counter itself sits in its own module; only clock, reset, clear and tick reach it
    wdit_count #(.WIDTH(WIDTH)) u_count (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_clear   (clr_pulse),
        .i_tick    (tick),
        .o_count   (wd_count)
    );

    // control word, restart sequencing, flag
    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            state                  <= ST_RUN;
            pulse_cnt              <= 4'h0;
            ctl                    <= `WDIT_CTL_RESET;
            boot_raw               <= 1'b1;
            prev_tap               <= 1'b0;
            clr_pulse              <= 1'b1;
            o_power_up_clear_reset <= 1'b0;
            o_wd_interval_flag     <= 1'b0;
            o_key_violation        <= 1'b0;
            o_wd_control_word      <= {`WDIT_KEY_READ, `WDIT_CTL_RESET};
            o_pin_nmi              <= 1'b0;
            o_pin_nmi_falling      <= 1'b0;
        end else begin
            state     <= next_state;
            prev_tap  <= tap && !clr_pulse;
            clr_pulse <= 1'b0;
            if (state == ST_RESET) begin
                // restart returns control to defaults, incl. reset pin mode
                pulse_cnt <= pulse_cnt + 4'h1;
                ctl       <= `WDIT_CTL_RESET;
                boot_raw  <= 1'b1;
                clr_pulse <= 1'b1;
                prev_tap  <= 1'b0;
            end else begin
                pulse_cnt <= 4'h0;
                if (wr_ok) begin
                    ctl       <= i_wdata[7:0] & ~(8'h01 << `WDIT_BIT_CLEAR);
                    boot_raw  <= 1'b0;
                    clr_pulse <= i_wdata[`WDIT_BIT_CLEAR];
                end
            end
            o_power_up_clear_reset <= (next_state == ST_RESET);
            // flag marks either interval expiry or watchdog cause; set beats clear
            if ((state == ST_RUN) && (expire || key_bad)) begin
                o_wd_interval_flag <= 1'b1;
            end else if (i_flag_clear) begin
                o_wd_interval_flag <= 1'b0;
            end
            o_key_violation   <= key_bad;
            o_wd_control_word <= {`WDIT_KEY_READ, (next_state == ST_RESET) ? `WDIT_CTL_RESET :
                                  (wr_ok ? (i_wdata[7:0] & 8'hf7) : ctl)};
            o_pin_nmi         <= (next_state == ST_RESET) ? 1'b0 :
                                 (wr_ok ? i_wdata[`WDIT_BIT_NMI] : ctl[`WDIT_BIT_NMI]);
            o_pin_nmi_falling <= (next_state == ST_RESET) ? 1'b0 :
                                 (wr_ok ? i_wdata[`WDIT_BIT_NMIES] : ctl[`WDIT_BIT_NMIES]);
        end
    end
endmodule // wdit_timer

/* File: verif/wdit_assertions.sv */
`timescale 1ns/10ps
module wdit_chk (
    input wire        i_ref_clk,
    input wire        i_rst_n,
    input wire        i_wr,
    input wire [15:0] i_wdata,
    input wire        i_flag_clear,
    input wire [15:0] o_wd_control_word,
    input wire        o_power_up_clear_reset,
    input wire        o_wd_interval_flag,
    input wire        o_key_violation,
    input wire        o_pin_nmi,
    input wire        o_pin_nmi_falling
);
    reg [15:0] wd_q;
    // write data one cycle back, since $past cannot be sliced
    always @(posedge i_ref_clk) wd_q <= i_wdata;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    a_read_key: assert property (o_wd_control_word[15:8] == 8'h69)
        else $error("upper byte not 69");
    a_clear_zero: assert property (o_wd_control_word[3] == 1'b0)
        else $error("clear bit reads 1");
    a_good_write: assert property (i_wr && i_wdata[15:8] == 8'h5a && !o_power_up_clear_reset
        |=> o_wd_control_word[7:0] == {wd_q[7:4], 1'b0, wd_q[2:0]}) else $error("write not applied");
    a_bad_key: assert property (i_wr && i_wdata[15:8] != 8'h5a && !o_power_up_clear_reset |=>
        o_key_violation && o_power_up_clear_reset && o_wd_control_word == 16'h6900) else $error("bad key");
    a_pulse_len: assert property ($rose(o_power_up_clear_reset) |->
        o_power_up_clear_reset[*5] ##1 !o_power_up_clear_reset) else $error("restart pulse length");
    a_nmi_copy: assert property ({o_pin_nmi_falling, o_pin_nmi} == o_wd_control_word[6:5])
        else $error("pin bits differ");
    a_flag_sticky: assert property (o_wd_interval_flag && !i_flag_clear |=> o_wd_interval_flag)
        else $error("flag dropped");
    a_interval_quiet: assert property ($rose(o_wd_interval_flag) && o_wd_control_word[4]
        |-> !o_power_up_clear_reset) else $error("restart in interval mode");
    a_halt_quiet: assert property (o_wd_control_word[7] && !o_wd_interval_flag && !i_wr
        |=> !o_wd_interval_flag) else $error("expiry while halted");
    cover property (o_key_violation);
    cover property ($rose(o_wd_interval_flag) && o_wd_control_word[4]);
    cover property (o_wd_control_word[7]);
endmodule // wdit_chk
bind wdit_timer wdit_chk i_chk (.*);

/* File: verif/wdit_tb.sv */
`timescale 1ns/10ps
module tb;
    reg         clk = 1'b0, rst_n = 1'b0, aux = 1'b0, sub = 1'b0, raw = 1'b1, wr = 1'b0, fc = 1'b0;
    reg         mt = 1'b0, af = 1'b0;
    reg  [15:0] wd = 16'h0000;
    reg  [31:0] s = 32'h0000e940;
    wire [15:0] ctl;
    wire        prst, flag, kv, nmi, nmif;
    integer     mismatches = 0, num_checks = 0, cyc = 0, n, c, p;
    wdit_timer i_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_aux_tick(aux), .i_sub_main_tick(sub),
        .i_raw_osc_tick(raw), .i_main_tick(mt), .i_aux_fail(af), .i_sub_main_fail(af), .i_wr(wr),
        .i_wdata(wd), .i_flag_clear(fc), .o_wd_control_word(ctl), .o_power_up_clear_reset(prst),
        .o_wd_interval_flag(flag), .o_key_violation(kv), .o_pin_nmi(nmi), .o_pin_nmi_falling(nmif));
    always #50 clk = ~clk;
    // hang guard, sized for the power-up expiry and the four full intervals plus margin
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc > 90000) begin
            mismatches = mismatches + 1;
            finish_test;
        end
    end
    function [31:0] xs(input [31:0] v);
        begin
            xs = v ^ (v << 13);
            xs = xs ^ (xs >> 17);
            xs = xs ^ (xs << 5);
        end
    endfunction
    task chk(input [15:0] g, input [15:0] e);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("unexpected at %0t: got %h want %h", $time, g, e);
            end
        end
    endtask
    // expiry timing gets a small window: the clear pulse and the flag register each add a cycle
    task rng(input integer v, input integer lo, input integer hi);
        begin
            num_checks = num_checks + 1;
            if (v < lo || v > hi) begin
                mismatches = mismatches + 1;
                $display("unexpected at %0t: got %h want %h", $time, v, lo);
            end
        end
    endtask
    task wrt(input [15:0] v);
        begin
            @(negedge clk) wr = 1'b1;
            wd = v;
            @(negedge clk) wr = 1'b0;
        end
    endtask
    task clr;
        begin
            @(negedge clk) fc = 1'b1;
            @(negedge clk) fc = 1'b0;
        end
    endtask
    task waitf(input integer lim);
        begin
            n = 0;
            while (flag !== 1'b1 && prst !== 1'b1 && n < lim) begin
                @(negedge clk);
                n = n + 1;
            end
        end
    endtask
    task finish_test;
        begin
            if (mismatches == 0 && num_checks > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    // main sequence: power-up expiry, random writes, bad key, every interval, halt
    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        chk(ctl, 16'h6900);
        waitf(40000);
        rng(n, 32766, 32771);
        chk({15'h0000, prst}, 16'h0001);
        repeat (6) @(negedge clk);
        clr;
        for (c = 0; c < 4; c = c + 1) begin
            s = xs(s);
            wrt({8'h5a, s[7:0]});
            chk(ctl, {8'h69, s[7:4], 1'b0, s[2:0]});
            chk({14'h0000, nmif, nmi}, {14'h0000, s[6:5]});
        end
        s = xs(s);
        wrt({(s[15:8] == 8'h5a) ? 8'h00 : s[15:8], s[7:0]});
        chk({13'h0000, kv, prst, flag}, 16'h0007);
        chk(ctl, 16'h6900);
        repeat (6) @(negedge clk);
        for (c = 0; c < 4; c = c + 1) begin
            p = 32768 >> (c == 0 ? 0 : c == 1 ? 2 : c == 2 ? 6 : 9);
            aux = c[0];
            sub = ~c[0];
            wrt({8'h5a, 4'h1, 1'b1, c[0], c[1:0]});
            clr;
            waitf(p + 10);
            rng(n + 2, p - 1, p + 2);
            chk({14'h0000, prst, flag}, 16'h0001);
        end
        wrt(16'h5a9f);
        clr;
        repeat (200) @(negedge clk);
        chk({15'h0000, flag}, 16'h0000);
        // failed auxiliary clock in watchdog mode: main clock keeps the count going
        @(negedge clk) aux = 1'b0;
        af = 1'b1;
        mt = 1'b1;
        wrt(16'h5a0f);
        waitf(80);
        rng(n, 65, 67);
        chk({15'h0000, prst}, 16'h0001);
        finish_test;
    end
endmodule // tb
